/* dv/ebps_ext_bus.sv */
`timescale 1ns/1ns
module ebps_ext_bus (
  input wire logic clk_i, // clock
  input wire logic [8:0] pin_out_i, // device drive level
  input wire logic [8:0] pin_oe_n_i, // device enable, low = drive
  input wire logic hold_req_i, // external master wants the bus
  output logic [8:0] pin_in_o // resolved pin levels
);
  logic tog = 1'b0;
  always @(posedge clk_i) tog <= ~tog;
  always_comb begin
    // undriven pins wander so stale levels are never trusted, except pin 7, which follows hold_req_i
    for (int k = 0; k < 9; k++) begin
      pin_in_o[k] = pin_oe_n_i[k] ? (tog ^ k[0]) : pin_out_i[k];
    end
    if (pin_oe_n_i[7]) pin_in_o[7] = hold_req_i;
  end
endmodule

/* dv/ebps_top_asserts.sv */
`timescale 1ns/1ns
module ebps_top_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [ADDR_W-1:0] reg_addr_i, // addr
  input wire logic [7:0] reg_wdata_i, // wdata
  input wire logic reg_wr_i, // write
  input wire logic reg_rd_i, // read
  input wire logic [7:0] reg_rdata_o, // rdata
  input wire logic [2:0] bus_addr_hi_i, // addr hi
  input wire logic bus_ale_i, // ale
  input wire logic bus_rd_n_i, // rd
  input wire logic bus_wr_lo_n_i, // low write strobe
  input wire logic bus_wr_hi_n_i, // high write strobe
  input wire logic bus_hold_ack_i, // hold acknowledge
  input wire logic bus_hold_req_o, // hold request
  input wire logic [8:0] pin_in_i, // pin in
  input wire logic [8:0] pin_out_o, // pin out
  input wire logic [8:0] pin_oe_n_o // pin oe
);
  logic [1:0] md;
  logic w16, wse, hold_en, ext, fl;
  logic [8:0] dat, dir, o;
  // shadow of the control registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md <= 2'h0;
      w16 <= 1'b0;
      wse <= 1'b0;
      hold_en <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == ADDR_W'(ebps_pkg::OFS_BUS_MODE)) begin
      w16 <= reg_wdata_i[2];
      if (reg_wdata_i[1:0] != 2'h3) md <= reg_wdata_i[1:0];
    end else if (reg_wr_i && reg_addr_i == ADDR_W'(ebps_pkg::OFS_PIN_CTRL)) begin
      wse <= reg_wdata_i[0];
      hold_en <= reg_wdata_i[1];
    end
  end
  // shadow of port data and direction
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dat <= '0;
      dir <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_W'(ebps_pkg::OFS_P4_DATA)) dat[2:0] <= reg_wdata_i[7:5];
      if (reg_addr_i == ADDR_W'(ebps_pkg::OFS_P4_DIR)) dir[2:0] <= reg_wdata_i[7:5];
      if (reg_addr_i == ADDR_W'(ebps_pkg::OFS_P5_DATA)) dat[8:3] <= reg_wdata_i[5:0];
      if (reg_addr_i == ADDR_W'(ebps_pkg::OFS_P5_DIR)) dir[8:3] <= reg_wdata_i[5:0];
    end
  end
  assign ext = (md == 2'h1) || (md == 2'h2);
  assign fl = ext && hold_en && bus_hold_ack_i;
  assign o = {ext && hold_en, ext && hold_en, ext && w16 && wse, ext && wse, ext, ext,
              {3{md == 2'h2}}};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_addr;
    $past(o[0] && !fl) |-> pin_out_o[2:0] == $past(bus_addr_hi_i) && pin_oe_n_o[2:0] == 3'h0;
  endproperty
  a_addr: assert property (p_addr) else $error("address pins wrong");
  property p_ale;
    $past(o[3] && !fl) |-> pin_out_o[3] == $past(bus_ale_i) && !pin_oe_n_o[3];
  endproperty
  a_ale: assert property (p_ale) else $error("latch enable pin wrong");
  property p_rd;
    $past(o[4] && !fl) |-> pin_out_o[4] == $past(bus_rd_n_i) && !pin_oe_n_o[4];
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe pin wrong");
  property p_wr_lo;
    $past(o[5] && !fl) |-> pin_out_o[5] == $past(bus_wr_lo_n_i) && !pin_oe_n_o[5];
  endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low write strobe pin wrong");
  property p_wr_hi;
    $past(o[6] && !fl) |-> pin_out_o[6] == $past(bus_wr_hi_n_i) && !pin_oe_n_o[6];
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high write strobe pin wrong");
  property p_hold_req;
    bus_hold_req_o == $past(o[7] && pin_in_i[7]) && (!$past(o[7]) || pin_oe_n_o[7]);
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("hold request wrong");
  property p_hold_ack;
    $past(o[8]) |-> pin_out_o[8] == $past(bus_hold_ack_i) && !pin_oe_n_o[8];
  endproperty
  a_hold_ack: assert property (p_hold_ack) else $error("hold acknowledge pin wrong");
  // owned outputs other than hold acknowledge let go of their pins while the hold is granted
  property p_float;
    $past(fl) |-> (pin_oe_n_o[6:0] | ~$past(o[6:0])) == 7'h7F;
  endproperty
  a_float: assert property (p_float) else $error("owned pin driven during hold");
  property p_gpio;
    (pin_out_o & ~$past(o)) == ($past(dat) & ~$past(o)) &&
      (pin_oe_n_o | $past(o)) == (~$past(dir) | $past(o));
  endproperty
  a_gpio: assert property (p_gpio) else $error("port pin wrong");
endmodule
bind ebps_top ebps_top_asserts #(.ADDR_W(ADDR_W)) i_ebps_top_asserts (.clk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_addr_hi_i, .bus_ale_i,
  .bus_rd_n_i, .bus_wr_lo_n_i, .bus_wr_hi_n_i, .bus_hold_ack_i, .bus_hold_req_o, .pin_in_i,
  .pin_out_o, .pin_oe_n_o);

/* dv/test_ebps_top.sv */
`timescale 1ns/1ns
module test_ebps_top;
  typedef struct packed {
    logic [1:0] md;
    logic w16;
    logic wse;
    logic hold_en;
    logic [8:0] out;
    logic [8:0] oe;
  } ebps_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, bus_ale_i = 1'b0, bus_rd_n_i = 1'b0;
  logic bus_wr_lo_n_i = 1'b0, bus_wr_hi_n_i = 1'b0, bus_hold_ack_i = 1'b0, hold_req = 1'b1;
  logic [2:0] bus_addr_hi_i = 3'h0;
  logic [7:0] reg_rdata_o;
  logic bus_hold_req_o;
  logic [8:0] pin_in_i, pin_out_o, pin_oe_n_o;
  int fail_count = 0, n_checks = 0, cyc = 0;
  ebps_row_t rows [8] = '{'{2'h0, 1'b0, 1'b1, 1'b1, 9'h1FF, 9'h000},
    '{2'h1, 1'b0, 1'b0, 1'b0, 9'h1E7, 9'h000}, '{2'h2, 1'b0, 1'b0, 1'b0, 9'h1E0, 9'h000},
    '{2'h1, 1'b0, 1'b1, 1'b0, 9'h1C7, 9'h000}, '{2'h1, 1'b1, 1'b0, 1'b0, 9'h1E7, 9'h000},
    '{2'h1, 1'b1, 1'b1, 1'b0, 9'h187, 9'h000}, '{2'h1, 1'b0, 1'b0, 1'b1, 9'h067, 9'h080},
    '{2'h2, 1'b1, 1'b1, 1'b1, 9'h000, 9'h080}};
  ebps_top #(.ADDR_W(8)) i_ebps_top (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .bus_addr_hi_i, .bus_ale_i, .bus_rd_n_i, .bus_wr_lo_n_i,
    .bus_wr_hi_n_i, .bus_hold_ack_i, .bus_hold_req_o, .pin_in_i, .pin_out_o, .pin_oe_n_o);
  ebps_ext_bus i_ebps_ext_bus (.clk_i, .pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
    .hold_req_i(hold_req), .pin_in_o(pin_in_i));
  always #10 clk_i = ~clk_i;
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk({1'b0, reg_rdata_o}, {1'b0, exp});
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task give_verdict();
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk(pin_oe_n_o, 9'h1FF);
    wr(ebps_pkg::OFS_P4_DATA, 8'hE0);
    wr(ebps_pkg::OFS_P4_DIR, 8'hE0);
    wr(ebps_pkg::OFS_P5_DATA, 8'h3F);
    wr(ebps_pkg::OFS_P5_DIR, 8'h3F);
    foreach (rows[i]) begin
      wr(ebps_pkg::OFS_BUS_MODE, {5'h00, rows[i].w16, rows[i].md});
      wr(ebps_pkg::OFS_PIN_CTRL, {6'h00, rows[i].hold_en, rows[i].wse});
      settle();
      chk(pin_out_o & ~rows[i].oe, rows[i].out & ~rows[i].oe);
      chk(pin_oe_n_o, rows[i].oe);
      chk({8'h00, bus_hold_req_o}, {8'h00, rows[i].hold_en && rows[i].md != 2'h0});
    end
    // every pin owned: distinct bus levels, port data cleared
    @(posedge clk_i);
    {bus_wr_hi_n_i, bus_wr_lo_n_i, bus_rd_n_i, bus_ale_i, bus_addr_hi_i} <= 7'h2E;
    wr(ebps_pkg::OFS_P4_DATA, 8'h00);
    wr(ebps_pkg::OFS_P5_DATA, 8'h00);
    settle();
    chk(pin_out_o & 9'h17F, 9'h02E);
    rd(ebps_pkg::OFS_OWNER_LO, 8'hFF);
    rd(ebps_pkg::OFS_OWNER_HI, 8'h03);
    rd(8'h20, 8'h00);
    rd(ebps_pkg::OFS_BUS_MODE, 8'h06);
    rd(ebps_pkg::OFS_PIN_CTRL, 8'h03);
    rd(ebps_pkg::OFS_P5_DATA, 8'h15);
    // every bus level inverted
    @(posedge clk_i);
    {bus_wr_hi_n_i, bus_wr_lo_n_i, bus_rd_n_i, bus_ale_i, bus_addr_hi_i} <= 7'h51;
    settle();
    chk(pin_out_o & 9'h17F, 9'h051);
    @(posedge clk_i);
    bus_hold_ack_i <= 1'b1;
    settle();
    chk(pin_out_o & 9'h100, 9'h100);
    chk(pin_oe_n_o, 9'h0FF);
    @(posedge clk_i);
    hold_req <= 1'b0;
    settle();
    chk({8'h00, bus_hold_req_o}, 9'h000);
    // back to single chip: port settings take the pins again
    wr(ebps_pkg::OFS_BUS_MODE, 8'h00);
    settle();
    chk(pin_out_o, 9'h000);
    chk(pin_oe_n_o, 9'h000);
    // mid-run reset: single chip mode, every pin an input again
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(pin_oe_n_o, 9'h1FF);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ebps_pkg::OFS_BUS_MODE, 8'h00);
    rd(ebps_pkg::OFS_P5_DIR, 8'h00);
    give_verdict();
  end
endmodule

/* src/ebps_mode_dec.sv */
`timescale 1ns/1ns
module ebps_mode_dec (
  input wire ebps_pkg::ebps_mode_t mode_i, // bus mode
  input wire logic width16_i, // 16-bit bus
  input wire logic wse_i, // write strobe pin enable
  input wire logic hold_en_i, // hold pins enable
  ebps_own_if.dec own_o // ownership out
);
  assign own_o.own = ebps_pkg::ebps_owner(mode_i, width16_i, wse_i, hold_en_i);
  assign own_o.ext = (mode_i != ebps_pkg::EBPS_SINGLE_CHIP);
endmodule

/* src/ebps_own_if.sv */
`timescale 1ns/1ns
interface ebps_own_if #(
  parameter int N = 9
);
  logic [N-1:0] own;
  logic ext;
  modport dec (output own, output ext);
  modport use_side (input own, input ext);
endinterface

/* src/ebps_pin_cell.sv */
`timescale 1ns/1ns
module ebps_pin_cell (
  input wire logic own_i, // bus function owns pin
  input wire logic bus_drive_i, // bus function is an output
  input wire logic bus_val_i, // bus function level
  input wire logic float_i, // bus released to another master
  input wire logic gpio_data_i, // port data bit
  input wire logic gpio_dir_i, // port direction, 1 = output
  output logic next_out_o, // next pin level
  output logic next_oe_n_o // next enable, low = drive
);
  always_comb begin
    // [RQ8] bus beats port settings
    if (own_i) begin
      next_out_o = bus_val_i;
      next_oe_n_o = !(bus_drive_i && !float_i);
    end else begin
      next_out_o = gpio_data_i;
      next_oe_n_o = !gpio_dir_i;
    end
  end
endmodule

/* src/ebps_pkg.sv */
package ebps_pkg;

  localparam int NUM_PINS = 9;
  localparam int DATA_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_P4_DATA = 8'h00;
  localparam logic [7:0] OFS_P4_DIR = 8'h04;
  localparam logic [7:0] OFS_P5_DATA = 8'h08;
  localparam logic [7:0] OFS_P5_DIR = 8'h0C;
  localparam logic [7:0] OFS_PIN_CTRL = 8'h10;
  localparam logic [7:0] OFS_BUS_MODE = 8'h14;
  localparam logic [7:0] OFS_OWNER_LO = 8'h18;
  localparam logic [7:0] OFS_OWNER_HI = 8'h1C;

  // field positions
  localparam int P4_LSB = 5;
  localparam int P4_W = 3;
  localparam int P5_LSB = 0;
  localparam int P5_W = 6;
  localparam int WSE_BIT = 0;
  localparam int HOLD_EN_BIT = 1;
  localparam int MODE_LSB = 0;
  localparam int WIDTH16_BIT = 2;

  // pin indices in the shared pin vector
  localparam int PIN_ADDR13 = 0;
  localparam int PIN_ADDR14 = 1;
  localparam int PIN_ADDR15 = 2;
  localparam int PIN_ALE = 3;
  localparam int PIN_RD = 4;
  localparam int PIN_WR_LO = 5;
  localparam int PIN_WR_HI = 6;
  localparam int PIN_HOLD_REQ = 7;
  localparam int PIN_HOLD_ACK = 8;

  typedef enum logic [1:0] {
    EBPS_SINGLE_CHIP = 2'h0,
    EBPS_EXT_MUX = 2'h1,
    EBPS_EXT_NONMUX = 2'h2
  } ebps_mode_t;

  localparam logic [1:0] MODE_RESERVED = 2'h3;

  // values after reset
  localparam logic [2:0] RST_P4 = 3'h0;
  localparam logic [5:0] RST_P5 = 6'h00;
  localparam logic RST_WSE = 1'b0;
  localparam logic RST_HOLD_EN = 1'b0;
  localparam logic RST_WIDTH16 = 1'b0;
  localparam ebps_mode_t RST_MODE = EBPS_SINGLE_CHIP;

  // which shared pins the bus controller owns
  function automatic logic [NUM_PINS-1:0] ebps_owner(input ebps_mode_t mode,
                                                     input logic width16,
                                                     input logic wse,
                                                     input logic hold_en);
    logic ext;
    logic [NUM_PINS-1:0] own;
    ext = (mode == EBPS_EXT_MUX) || (mode == EBPS_EXT_NONMUX);
    own = '0;
    // [RQ1] upper address pins
    own[PIN_ADDR13] = (mode == EBPS_EXT_NONMUX);
    own[PIN_ADDR14] = (mode == EBPS_EXT_NONMUX);
    own[PIN_ADDR15] = (mode == EBPS_EXT_NONMUX);
    // [RQ2] latch enable pin
    own[PIN_ALE] = ext;
    // [RQ3] read strobe pin
    own[PIN_RD] = ext;
    // [RQ4] low write strobe
    own[PIN_WR_LO] = ext && wse;
    // [RQ5] high write strobe
    own[PIN_WR_HI] = ext && width16 && wse;
    // [RQ6] hold request input
    own[PIN_HOLD_REQ] = ext && hold_en;
    // [RQ7] hold acknowledge output
    own[PIN_HOLD_ACK] = ext && hold_en;
    return own;
  endfunction

endpackage

/* src/ebps_top.sv */
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
// What this block does
// [RQ1] Non-multiplexed bus mode drives address bits 13 to 15 on port4 bits 5-7.
// [RQ2] External bus mode puts address latch enable on port5 bit0, else GPIO.
// [RQ3] External bus mode puts active-low read strobe on port5 bit1, else GPIO.
// [RQ4] External bus with write strobe enable puts low write strobe on port5 bit2.
// [RQ5] High write strobe on port5 bit3 needs external bus, 16-bit width, enable.
// [RQ6] External bus with hold enable takes port5 bit4 as hold request input.
// [RQ7] External bus with hold enable drives hold acknowledge on port5 bit5.
// [RQ8] A bus-owned pin follows the bus controller, ignoring port data and direction.
module ebps_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [ADDR_W-1:0] reg_addr_i, // register address
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [7:0] reg_rdata_o, // read data, cycle after read
  input wire logic [2:0] bus_addr_hi_i, // address bits 15..13
  input wire logic bus_ale_i, // latch enable from controller
  input wire logic bus_rd_n_i, // read strobe, low active
  input wire logic bus_wr_lo_n_i, // low byte write strobe, low active
  input wire logic bus_wr_hi_n_i, // high byte write strobe, low active
  input wire logic bus_hold_ack_i, // hold acknowledge from controller
  output logic bus_hold_req_o, // hold request to controller
  input wire logic [8:0] pin_in_i, // shared pin levels
  output logic [8:0] pin_out_o, // shared pin drive level
  output logic [8:0] pin_oe_n_o // shared pin enable, low = drive
);

  if (ADDR_W < 5) begin : g_chk
    $error("ebps_top: ADDR_W must be at least 5");
  end

  localparam int N = ebps_pkg::NUM_PINS;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  logic [2:0] p4_data;
  logic [2:0] p4_dir;
  logic [5:0] p5_data;
  logic [5:0] p5_dir;
  logic wse;
  logic hold_en;
  logic width16;
  ebps_pkg::ebps_mode_t mode;
  logic [N-1:0] gpio_data;
  logic [N-1:0] gpio_dir;
  logic [N-1:0] bus_val;
  logic [N-1:0] next_out;
  logic [N-1:0] next_oe_n;
  logic [N-1:0] pin_view;
  logic [7:0] next_rdata;
  logic bus_float;

  ebps_own_if #(.N(N)) own_if ();

  ebps_mode_dec u_dec (
    .mode_i(mode),
    .width16_i(width16),
    .wse_i(wse),
    .hold_en_i(hold_en),
    .own_o(own_if)
  );

  // port data registers, kept even while bus owns the pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p4_data <= ebps_pkg::RST_P4;
      p5_data <= ebps_pkg::RST_P5;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, ebps_pkg::OFS_P4_DATA)) begin
        p4_data <= reg_wdata_i[ebps_pkg::P4_LSB +: ebps_pkg::P4_W];
      end
      if (hit(reg_addr_i, ebps_pkg::OFS_P5_DATA)) begin
        p5_data <= reg_wdata_i[ebps_pkg::P5_LSB +: ebps_pkg::P5_W];
      end
    end
  end

  // port direction registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p4_dir <= ebps_pkg::RST_P4;
      p5_dir <= ebps_pkg::RST_P5;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, ebps_pkg::OFS_P4_DIR)) begin
        p4_dir <= reg_wdata_i[ebps_pkg::P4_LSB +: ebps_pkg::P4_W];
      end
      if (hit(reg_addr_i, ebps_pkg::OFS_P5_DIR)) begin
        p5_dir <= reg_wdata_i[ebps_pkg::P5_LSB +: ebps_pkg::P5_W];
      end
    end
  end

  // pin control enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wse <= ebps_pkg::RST_WSE;
      hold_en <= ebps_pkg::RST_HOLD_EN;
    end else if (reg_wr_i && hit(reg_addr_i, ebps_pkg::OFS_PIN_CTRL)) begin
      wse <= reg_wdata_i[ebps_pkg::WSE_BIT];
      hold_en <= reg_wdata_i[ebps_pkg::HOLD_EN_BIT];
    end
  end

  // bus mode and width; reserved mode code leaves mode unchanged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode <= ebps_pkg::RST_MODE;
      width16 <= ebps_pkg::RST_WIDTH16;
    end else if (reg_wr_i && hit(reg_addr_i, ebps_pkg::OFS_BUS_MODE)) begin
      width16 <= reg_wdata_i[ebps_pkg::WIDTH16_BIT];
      if (reg_wdata_i[ebps_pkg::MODE_LSB +: 2] != ebps_pkg::MODE_RESERVED) begin
        mode <= ebps_pkg::ebps_mode_t'(reg_wdata_i[ebps_pkg::MODE_LSB +: 2]);
      end
    end
  end

  assign gpio_data = {p5_data, p4_data};
  assign gpio_dir = {p5_dir, p4_dir};

  // bus-side level for each pin; the hold request slot carries nothing out
  assign bus_val = {bus_hold_ack_i, 1'b0, bus_wr_hi_n_i, bus_wr_lo_n_i, bus_rd_n_i,
                    bus_ale_i, bus_addr_hi_i};

  // while the hold is granted the strobes and address let go of the pins
  assign bus_float = own_if.own[ebps_pkg::PIN_HOLD_ACK] && bus_hold_ack_i;

  for (genvar i = 0; i < N; i++) begin : g_pin
    localparam logic IS_OUT = (i != ebps_pkg::PIN_HOLD_REQ);
    localparam logic CAN_FLOAT = (i != ebps_pkg::PIN_HOLD_ACK);
    // [RQ8] per-pin bus or port mux
    ebps_pin_cell u_cell (
      .own_i(own_if.own[i]),
      .bus_drive_i(IS_OUT),
      .bus_val_i(bus_val[i]),
      .float_i(bus_float && CAN_FLOAT),
      .gpio_data_i(gpio_data[i]),
      .gpio_dir_i(gpio_dir[i]),
      .next_out_o(next_out[i]),
      .next_oe_n_o(next_oe_n[i])
    );
    // read back: driven port pins show the latch, others the pin
    assign pin_view[i] = (gpio_dir[i] && !own_if.own[i]) ? gpio_data[i] : pin_in_i[i];
  end

  // registered pin drive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o <= '0;
      pin_oe_n_o <= '1;
    end else begin
      pin_out_o <= next_out;
      pin_oe_n_o <= next_oe_n;
    end
  end

  // [RQ6] hold request taken from pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_hold_req_o <= 1'b0;
    end else begin
      bus_hold_req_o <= own_if.own[ebps_pkg::PIN_HOLD_REQ] &&
                        pin_in_i[ebps_pkg::PIN_HOLD_REQ];
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (hit(reg_addr_i, ebps_pkg::OFS_P4_DATA)) begin
      next_rdata[ebps_pkg::P4_LSB +: ebps_pkg::P4_W] = pin_view[2:0];
    end else if (hit(reg_addr_i, ebps_pkg::OFS_P4_DIR)) begin
      next_rdata[ebps_pkg::P4_LSB +: ebps_pkg::P4_W] = p4_dir;
    end else if (hit(reg_addr_i, ebps_pkg::OFS_P5_DATA)) begin
      next_rdata[ebps_pkg::P5_LSB +: ebps_pkg::P5_W] = pin_view[8:3];
    end else if (hit(reg_addr_i, ebps_pkg::OFS_P5_DIR)) begin
      next_rdata[ebps_pkg::P5_LSB +: ebps_pkg::P5_W] = p5_dir;
    end else if (hit(reg_addr_i, ebps_pkg::OFS_PIN_CTRL)) begin
      next_rdata[ebps_pkg::WSE_BIT] = wse;
      next_rdata[ebps_pkg::HOLD_EN_BIT] = hold_en;
    end else if (hit(reg_addr_i, ebps_pkg::OFS_BUS_MODE)) begin
      next_rdata[ebps_pkg::MODE_LSB +: 2] = mode;
      next_rdata[ebps_pkg::WIDTH16_BIT] = width16;
    end else if (hit(reg_addr_i, ebps_pkg::OFS_OWNER_LO)) begin
      next_rdata = own_if.own[7:0];
    end else if (hit(reg_addr_i, ebps_pkg::OFS_OWNER_HI)) begin
      next_rdata[0] = own_if.own[8];
      next_rdata[1] = own_if.ext;
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule
